// [include/coding_status_pkg.sv]
// Constants for the coding sublayer status register bank.
// Assumes a management front end that supplies decoded 16-bit reads.
package coding_status_pkg;
    localparam logic [4:0] DEVICE_ADDR = 5'h03;
    localparam logic [15:0] PRIMARY_OFFSET = 16'h0001;
    localparam logic [15:0] SECONDARY_OFFSET = 16'h0008;
    localparam logic [15:0] BACKPLANE_OFFSET = 16'h0020;
    localparam logic [15:0] PRIMARY_RESET = 16'h0002;
    localparam logic [15:0] SECONDARY_RESET = 16'h8001;
    localparam logic [15:0] BACKPLANE_RESET = 16'h0004;
    localparam int FAULT_BIT = 7;
    localparam int RX_LINK_BIT = 2;
    localparam int LOW_POWER_BIT = 1;
    localparam int PRESENCE_HI = 15;
    localparam int PRESENCE_LO = 14;
    localparam logic [1:0] PRESENCE_CODE = 2'h2;
    localparam int TX_FAULT_BIT = 11;
    localparam int RX_FAULT_BIT = 10;
    localparam int R_TYPE_BIT = 0;
    localparam int BP_LINK_BIT = 12;
    localparam int PRBS_BIT = 2;
    localparam int HI_BER_BIT = 1;
    localparam int LOCK_BIT = 0;
endpackage

// [rtl/latch_flag.sv]
// Latching status flag: holds an abnormal value until read, then tracks live.
// Assumes read_i is a one-cycle pulse for the read that returns the flag.
`timescale 1ns/10ps
module latch_flag #(
    parameter logic LATCH_VALUE = 1'b1,
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic live_i,
    input wire logic read_i,
    output logic flag_o
);
    typedef struct packed {
        logic flag;
    } state_s;
    state_s st_q, st_d;
    always_comb begin
        st_d = st_q;
        // Latched event wins over the clearing read
        if (live_i == LATCH_VALUE) begin
            st_d.flag = LATCH_VALUE;
        end else if (read_i) begin
            st_d.flag = live_i;
        end
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= '{flag: RESET_VALUE};
        end else begin
            st_q <= st_d;
        end
    end
    assign flag_o = st_q.flag;
endmodule

// [rtl/coding_layer_status_regs.sv]
// Status register bank of the coding sublayer, read by the management block.
// Assumes the management front end decodes frames and pulses rd_en_i.
`timescale 1ns/10ps
module coding_layer_status_regs (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic rd_en_i,
    input wire logic [4:0] rd_dev_i,
    input wire logic [15:0] rd_addr_i,
    input wire logic tx_fault_i,
    input wire logic rx_fault_i,
    input wire logic rx_link_i,
    input wire logic hi_ber_i,
    input wire logic block_lock_i,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o,
    output logic summary_fault_flag_o
);
    import coding_status_pkg::*;

    typedef struct packed {
        logic [15:0] rd_data;
        logic rd_valid;
        logic summary_fault;
        logic bp_link;
        logic bp_ber;
        logic bp_lock;
    } state_s;

    state_s st_q, st_d;
    logic dev_ok, rd_primary, rd_secondary, rd_backplane;
    logic link_flag, txf_flag, rxf_flag;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction

    // Device address filter
    assign dev_ok = rd_en_i && (rd_dev_i == DEVICE_ADDR);
    assign rd_primary = dev_ok && hit(rd_addr_i, PRIMARY_OFFSET);
    assign rd_secondary = dev_ok && hit(rd_addr_i, SECONDARY_OFFSET);
    assign rd_backplane = dev_ok && hit(rd_addr_i, BACKPLANE_OFFSET);

    latch_flag #(.LATCH_VALUE(1'b0), .RESET_VALUE(1'b1)) u_link (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .live_i(rx_link_i),
        .read_i(rd_primary),
        .flag_o(link_flag)
    );
    latch_flag #(.LATCH_VALUE(1'b1), .RESET_VALUE(1'b0)) u_txf (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .live_i(tx_fault_i),
        .read_i(rd_secondary),
        .flag_o(txf_flag)
    );
    latch_flag #(.LATCH_VALUE(1'b1), .RESET_VALUE(1'b0)) u_rxf (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .live_i(rx_fault_i),
        .read_i(rd_secondary),
        .flag_o(rxf_flag)
    );

    always_comb begin
        logic [15:0] word;
        word = 16'h0000;
        st_d = st_q;
        st_d.bp_link = rx_link_i;
        st_d.bp_ber = hi_ber_i;
        st_d.bp_lock = block_lock_i;
        // Summary fault set wins over the read that would clear it
        if (tx_fault_i || rx_fault_i) begin
            st_d.summary_fault = 1'b1;
        end else if (rd_secondary) begin
            st_d.summary_fault = 1'b0;
        end
        if (dev_ok && hit(rd_addr_i, PRIMARY_OFFSET)) begin
            word[FAULT_BIT] = st_q.summary_fault;
            word[RX_LINK_BIT] = link_flag;
            word[LOW_POWER_BIT] = 1'b1;
        end else if (dev_ok && hit(rd_addr_i, SECONDARY_OFFSET)) begin
            word[PRESENCE_HI:PRESENCE_LO] = PRESENCE_CODE;
            word[TX_FAULT_BIT] = txf_flag;
            word[RX_FAULT_BIT] = rxf_flag;
            word[R_TYPE_BIT] = 1'b1;
        end else if (dev_ok && hit(rd_addr_i, BACKPLANE_OFFSET)) begin
            word[BP_LINK_BIT] = st_q.bp_link;
            word[PRBS_BIT] = 1'b1;
            word[HI_BER_BIT] = st_q.bp_ber;
            word[LOCK_BIT] = st_q.bp_lock;
        end
        st_d.rd_data = dev_ok ? word : st_q.rd_data;
        st_d.rd_valid = dev_ok;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= '{
                rd_data: 16'h0000,
                rd_valid: 1'b0,
                summary_fault: PRIMARY_RESET[FAULT_BIT],
                bp_link: BACKPLANE_RESET[BP_LINK_BIT],
                bp_ber: BACKPLANE_RESET[HI_BER_BIT],
                bp_lock: BACKPLANE_RESET[LOCK_BIT]
            };
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data_o = st_q.rd_data;
    assign rd_valid_o = st_q.rd_valid;
    assign summary_fault_flag_o = st_q.summary_fault;

    a_fault_sets: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (tx_fault_i || rx_fault_i) |=> summary_fault_flag_o)
        else $error("summary fault not set");

    a_fault_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!summary_fault_flag_o && !tx_fault_i && !rx_fault_i) |=> !summary_fault_flag_o)
        else $error("summary fault set without a fault");

    a_fault_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (summary_fault_flag_o && !rd_secondary) |=> summary_fault_flag_o)
        else $error("summary fault cleared without read");

    a_fault_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (rd_secondary && !tx_fault_i && !rx_fault_i) |=> !summary_fault_flag_o)
        else $error("summary fault kept after clean read");

    a_link_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!rx_link_i) |=> !link_flag)
        else $error("link flag did not latch low");

    a_link_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!link_flag && !rd_primary) |=> !link_flag)
        else $error("link flag rose without read");

    a_link_rearm: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (rd_primary && rx_link_i) |=> link_flag)
        else $error("link flag not rearmed by read");

    a_txf_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        tx_fault_i |=> txf_flag)
        else $error("tx fault flag not latched");

    a_txf_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (txf_flag && !rd_secondary) |=> txf_flag)
        else $error("tx fault flag dropped without read");

    a_txf_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (rd_secondary && !tx_fault_i) |=> !txf_flag)
        else $error("tx fault flag kept after read");

    a_rxf_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rx_fault_i |=> rxf_flag)
        else $error("rx fault flag not latched");

    a_rxf_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (rd_secondary && !rx_fault_i) |=> !rxf_flag)
        else $error("rx fault flag kept after read");

    a_primary_fixed: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_primary |=> rd_data_o[LOW_POWER_BIT] && (rd_data_o[15:8] == 8'h00)
        && (rd_data_o[6:3] == 4'h0) && !rd_data_o[0])
        else $error("low power bit wrong");

    a_primary_word: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_primary |=> (rd_data_o[FAULT_BIT] == $past(summary_fault_flag_o))
        && (rd_data_o[RX_LINK_BIT] == $past(link_flag)))
        else $error("primary flags wrong");

    a_secondary_fixed: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_secondary |=> (rd_data_o[PRESENCE_HI:PRESENCE_LO] == PRESENCE_CODE)
        && rd_data_o[R_TYPE_BIT] && (rd_data_o[9:1] == 9'h000) && (rd_data_o[13:12] == 2'h0))
        else $error("secondary fixed bits wrong");

    a_secondary_word: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_secondary |=> (rd_data_o[TX_FAULT_BIT] == $past(txf_flag))
        && (rd_data_o[RX_FAULT_BIT] == $past(rxf_flag)))
        else $error("secondary fault flags wrong");

    a_backplane_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (rd_backplane && !$past(sys_rst_i)) |=> rd_data_o[PRBS_BIT] && rd_valid_o
        && (rd_data_o[BP_LINK_BIT] == $past(rx_link_i, 2)))
        else $error("backplane word wrong");

    a_backplane_fields: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (rd_backplane && !$past(sys_rst_i)) |=> (rd_data_o[HI_BER_BIT] == $past(hi_ber_i, 2))
        && (rd_data_o[LOCK_BIT] == $past(block_lock_i, 2)))
        else $error("backplane error rate or lock wrong");

    a_backplane_reserved: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_backplane |=> (rd_data_o[15:13] == 3'h0) && (rd_data_o[11:3] == 9'h000))
        else $error("backplane reserved bits set");

    a_read_answered: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        dev_ok |=> rd_valid_o)
        else $error("accepted read not answered");

    a_refused_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !dev_ok |=> !rd_valid_o && $stable(rd_data_o))
        else $error("refused read changed the answer");

    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (dev_ok && !rd_primary && !rd_secondary && !rd_backplane) |=> (rd_data_o == 16'h0000))
        else $error("unmapped read not zero");
endmodule

// [verification/mgmt_reader.sv]
// Station management model: issues single register reads to the bank.
// Assumes the bank answers with rd_valid_i one cycle after the request.
`timescale 1ns/10ps
module mgmt_reader (
    input wire logic clk_i,
    input wire logic rd_valid_i,
    input wire logic [15:0] rd_data_i,
    output logic rd_en_o,
    output logic [4:0] rd_dev_o,
    output logic [15:0] rd_addr_o
);
    initial begin
        rd_en_o = 1'b0;
        rd_dev_o = 5'h00;
        rd_addr_o = 16'h0000;
    end
    // One read and one idle cycle; answer taken just after the accepting edge
    task automatic rd(input logic [4:0] dev, input logic [15:0] addr,
                      output logic [15:0] d, output logic v);
        rd_en_o = 1'b1;
        rd_dev_o = dev;
        rd_addr_o = addr;
        @(posedge clk_i);
        #1;
        d = rd_data_i;
        v = rd_valid_i;
        rd_en_o = 1'b0;
        rd_dev_o = ~dev;
        rd_addr_o = ~addr;
        @(posedge clk_i);
        #1;
    endtask
endmodule

// [verification/tb_coding_layer_status_regs.sv]
// Bench for the coding sublayer status bank.
// Assumes the management reader model in mgmt_reader.sv.
`timescale 1ns/10ps
module tb_coding_layer_status_regs;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic tx_fault_i = 1'b0;
    logic rx_fault_i = 1'b0;
    logic rx_link_i = 1'b0;
    logic hi_ber_i = 1'b0;
    logic block_lock_i = 1'b0;
    logic rd_en_i, rd_valid_o, summary_fault_flag_o, v;
    logic [4:0] rd_dev_i;
    logic [15:0] rd_addr_i, rd_data_o, d;
    int fail_count = 0;
    int checked = 0;
    always #20 clk_i = ~clk_i;
    coding_layer_status_regs u_coding_layer_status_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .rd_en_i(rd_en_i), .rd_dev_i(rd_dev_i), .rd_addr_i(rd_addr_i), .tx_fault_i(tx_fault_i),
        .rx_fault_i(rx_fault_i), .rx_link_i(rx_link_i), .hi_ber_i(hi_ber_i),
        .block_lock_i(block_lock_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .summary_fault_flag_o(summary_fault_flag_o));
    mgmt_reader u_mgmt_reader (.clk_i(clk_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
        .rd_en_o(rd_en_i), .rd_dev_o(rd_dev_i), .rd_addr_o(rd_addr_i));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        u_mgmt_reader.rd(5'h03, a, d, v);
        chk({15'h0000, v}, 16'h0001);
        chk(d, exp);
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic t_reset;
        rdc(16'h0020, 16'h0004);
        rdc(16'h0008, 16'h8001);
        rdc(16'h0001, 16'h0002);
    endtask
    task automatic t_fault;
        for (int i = 0; i < 2; i++) begin
            tx_fault_i = (i == 0);
            rx_fault_i = (i == 1);
            hold(2);
            chk({15'h0000, summary_fault_flag_o}, 16'h0001);
            tx_fault_i = 1'b0;
            rx_fault_i = 1'b0;
            hold(2);
            rdc(16'h0001, 16'h0082);
            chk({15'h0000, summary_fault_flag_o}, 16'h0001);
            rdc(16'h0008, (i == 0) ? 16'h8801 : 16'h8401);
            rdc(16'h0008, 16'h8001);
            chk({15'h0000, summary_fault_flag_o}, 16'h0000);
        end
    endtask
    task automatic t_link;
        rx_link_i = 1'b1;
        hi_ber_i = 1'b1;
        block_lock_i = 1'b1;
        hold(3);
        rdc(16'h0020, 16'h1007);
        rdc(16'h0001, 16'h0002);
        rdc(16'h0001, 16'h0006);
        rx_link_i = 1'b0;
        hold(2);
        rx_link_i = 1'b1;
        hold(3);
        rdc(16'h0001, 16'h0002);
        rdc(16'h0001, 16'h0006);
        hi_ber_i = 1'b0;
        hold(2);
        rdc(16'h0020, 16'h1005);
    endtask
    task automatic t_clash;
        tx_fault_i = 1'b1;
        hold(1);
        rdc(16'h0008, 16'h8801);
        chk({15'h0000, summary_fault_flag_o}, 16'h0001);
        rdc(16'h0008, 16'h8801);
        tx_fault_i = 1'b0;
        rdc(16'h0008, 16'h8801);
        chk({15'h0000, summary_fault_flag_o}, 16'h0000);
        rdc(16'h0008, 16'h8001);
    endtask
    task automatic t_rerst;
        tx_fault_i = 1'b1;
        hold(1);
        tx_fault_i = 1'b0;
        sys_rst_i = 1'b1;
        hold(2);
        chk({15'h0000, summary_fault_flag_o}, 16'h0000);
        sys_rst_i = 1'b0;
        rdc(16'h0008, 16'h8001);
        chk({15'h0000, summary_fault_flag_o}, 16'h0000);
        rdc(16'h0001, 16'h0006);
    endtask
    task automatic t_refuse;
        u_mgmt_reader.rd(5'h01, 16'h0008, d, v);
        chk({15'h0000, v}, 16'h0000);
        chk(d, 16'h0006);
        rdc(16'h0003, 16'h0000);
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        hold(10);
        sys_rst_i = 1'b0;
        t_reset();
        t_fault();
        t_clash();
        t_link();
        t_rerst();
        t_refuse();
        report_and_stop();
    end
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
endmodule
